// ---- hdl/pattern_gen_pkg.sv ----
// Package: constants, register map and types of the four-output pattern generator
package pattern_gen_pkg;
  // Clock and time base
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_MIN_NS = 20;
  localparam int SAMPLE_MIN_CYC_I = (SAMPLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [31:0] SAMPLE_MIN_CYC = 32'(SAMPLE_MIN_CYC_I);
  localparam longint TIME_MAX_MS = 42000;
  localparam longint GAP_RESET_MS = 250;
  localparam longint CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
  localparam logic [31:0] TIME_MAX_CYC = 32'(TIME_MAX_MS * CYC_PER_MS);
  localparam logic [31:0] GAP_RESET_CYC = 32'(GAP_RESET_MS * CYC_PER_MS);

  // Pattern memory and burst
  localparam int DEPTH = 2048;
  localparam int AW = 11;
  localparam int LW = 12;
  localparam int SW = 4;
  localparam logic [LW-1:0] LEN_RESET = 12'h001;
  localparam logic [LW-1:0] LEN_MAX = 12'h800;
  localparam int CW = 13;
  localparam logic [CW-1:0] BURST_MAX = 13'h1000;
  localparam logic [CW-1:0] BURST_RESET = 13'h0001;

  // PWM
  localparam int DW = 7;
  localparam logic [DW-1:0] DUTY_MIN = 7'h01;
  localparam logic [DW-1:0] DUTY_MAX = 7'h63;
  localparam logic [DW-1:0] DUTY_RESET = 7'h32;
  localparam logic [DW-1:0] PWM_STEPS = 7'h64;
  localparam int PWM_TICK_CYC = 10;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_LENGTH = 8'h04;
  localparam logic [7:0] REG_INDEX = 8'h08;
  localparam logic [7:0] REG_APPEND = 8'h0c;
  localparam logic [7:0] REG_SAMPLE = 8'h10;
  localparam logic [7:0] REG_GAP = 8'h14;
  localparam logic [7:0] REG_COUNT = 8'h18;
  localparam logic [7:0] REG_MANUAL = 8'h1c;
  localparam logic [7:0] REG_MOTOR = 8'h20;
  localparam logic [7:0] REG_RED = 8'h24;
  localparam logic [7:0] REG_GREEN = 8'h28;
  localparam logic [7:0] REG_BLUE = 8'h2c;
  localparam logic [7:0] REG_BRIGHT = 8'h30;
  localparam logic [7:0] REG_TRIGGER = 8'h34;
  localparam logic [7:0] REG_STATUS = 8'h38;

  // Append data word fields
  localparam int APPEND_DATA_LSB = 0;
  localparam int APPEND_OP_LSB = 4;

  typedef enum logic [1:0] {
    MODE_PATTERN = 2'h0,
    MODE_MANUAL = 2'h1,
    MODE_MOTOR = 2'h2,
    MODE_LED = 2'h3
  } out_mode_t;

  typedef enum logic [1:0] {
    SLOPE_RISE = 2'h0,
    SLOPE_FALL = 2'h1,
    SLOPE_BOTH = 2'h2
  } slope_t;

  typedef enum logic [1:0] {
    APPEND_OVERWRITE = 2'h0,
    APPEND_OR_MERGE = 2'h1,
    APPEND_AND_MERGE = 2'h2
  } append_op_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_PLAY = 3'b010,
    SEQ_GAP = 3'b100
  } seq_state_t;

  // Control word, mode in the low bits
  typedef struct packed {
    logic motor_enable;
    logic motor_dir;
    slope_t slope;
    logic one_shot_trigger;
    logic burst_enable;
    logic run;
    out_mode_t mode;
  } ctrl_t;
  localparam int CTRL_W = $bits(ctrl_t);
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // Limit a written value to a range
  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
endpackage

// ---- hdl/pwm_channel.sv ----
// One PWM output with a duty in percent, stepped by a shared tick
`timescale 1ns/10ps
`default_nettype none
module pwm_channel
  import pattern_gen_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Step tick and duty
  input wire logic step,
  input wire logic [DW-1:0] duty,
  // PWM level
  output logic pwm_q
);
  logic [DW-1:0] cnt_q;

  // Percent counter, one period every PWM_STEPS ticks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else if (step) begin
      cnt_q <= (cnt_q == PWM_STEPS - 7'h01) ? '0 : cnt_q + 7'h01;
    end
  end

  // High for duty of every hundred steps
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pwm_q <= 1'b0;
    end else begin
      pwm_q <= (cnt_q < duty);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pattern_generator.sv ----
// Four-output pattern generator: pattern memory, sequencer, manual levels and PWM
`timescale 1ns/10ps
`default_nettype none
module pattern_generator
  import pattern_gen_pkg::*;
#(
  parameter logic [31:0] SAMPLE_MAX_CYC = TIME_MAX_CYC,
  parameter logic [31:0] GAP_MAX_CYC = TIME_MAX_CYC,
  parameter logic [31:0] GAP_DEFAULT_CYC = GAP_RESET_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  // External pattern trigger
  input wire logic ext_trig,
  // Output pins
  output logic [SW-1:0] pattern_out_q
);
  ctrl_t ctrl_q;
  logic [SW-1:0] mem_q [DEPTH];
  logic [LW-1:0] length_q;
  logic [AW-1:0] index_q;
  logic [31:0] sample_period_q;
  logic [31:0] gap_duration_q;
  logic [CW-1:0] burst_repeat_count_q;
  logic [SW-1:0] manual_q;
  logic [DW-1:0] motor_duty_q;
  logic [DW-1:0] duty_setting_q [3];
  logic [DW-1:0] brightness_duty_q;
  logic trig_cmd_q;
  logic ext_prev_q;
  seq_state_t state_q;
  logic [AW-1:0] addr_q;
  logic [31:0] timer_q;
  logic [CW-1:0] passes_q;
  logic [3:0] tick_cnt_q;
  logic tick_q;
  logic [3:0] pwm_w;

  logic wr_append, start, ext_edge, sample_done, last_sample;
  logic [SW-1:0] append_val, stored, merged;
  append_op_t append_op;

  assign wr_append = reg_wr && (reg_addr == REG_APPEND);
  assign append_val = reg_wdata[APPEND_DATA_LSB +: SW];
  assign append_op = append_op_t'(reg_wdata[APPEND_OP_LSB +: 2]);
  assign stored = mem_q[index_q];

  // Merge of new sample with stored one
  always_comb begin
    case (append_op)
      APPEND_OR_MERGE: merged = stored | append_val;
      APPEND_AND_MERGE: merged = stored & append_val;
      default: merged = append_val;
    endcase
  end

  // Pattern memory, one sample per append write
  always_ff @(posedge clk) begin
    if (wr_append) begin
      mem_q[index_q] <= merged;
    end
  end

  // Control word and configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= ctrl_t'(CTRL_RESET);
      sample_period_q <= SAMPLE_MIN_CYC;
      gap_duration_q <= GAP_DEFAULT_CYC;
      burst_repeat_count_q <= BURST_RESET;
      manual_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_CTRL: ctrl_q <= ctrl_t'(reg_wdata[CTRL_W-1:0]);
        REG_SAMPLE: sample_period_q <= clamp(reg_wdata, SAMPLE_MIN_CYC, SAMPLE_MAX_CYC);
        REG_GAP: begin
          if (ctrl_q.burst_enable) begin
            gap_duration_q <= clamp(reg_wdata, SAMPLE_MIN_CYC, GAP_MAX_CYC);
          end
        end
        REG_COUNT: begin
          if (ctrl_q.burst_enable) begin
            burst_repeat_count_q <= CW'(clamp(reg_wdata, 32'(BURST_RESET), 32'(BURST_MAX)));
          end
        end
        REG_MANUAL: manual_q <= reg_wdata[SW-1:0];
        default: ;
      endcase
    end
  end

  // Duty registers, clamped to 1..99 percent
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      motor_duty_q <= DUTY_RESET;
      for (int i = 0; i < 3; i++) begin
        duty_setting_q[i] <= DUTY_RESET;
      end
      brightness_duty_q <= DUTY_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        REG_MOTOR: motor_duty_q <= DW'(clamp(reg_wdata, 32'(DUTY_MIN), 32'(DUTY_MAX)));
        REG_RED: duty_setting_q[0] <= DW'(clamp(reg_wdata, 32'(DUTY_MIN), 32'(DUTY_MAX)));
        REG_GREEN: duty_setting_q[1] <= DW'(clamp(reg_wdata, 32'(DUTY_MIN), 32'(DUTY_MAX)));
        REG_BLUE: duty_setting_q[2] <= DW'(clamp(reg_wdata, 32'(DUTY_MIN), 32'(DUTY_MAX)));
        REG_BRIGHT: brightness_duty_q <= DW'(clamp(reg_wdata, 32'(DUTY_MIN), 32'(DUTY_MAX)));
        default: ;
      endcase
    end
  end

  // Length and append index; an append sets length to index plus one and moves the index along, holding at the top
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      length_q <= LEN_RESET;
      index_q <= '0;
    end else if (wr_append) begin
      length_q <= LW'(index_q) + 12'h001;
      if (index_q != AW'(DEPTH - 1)) begin
        index_q <= index_q + 11'h001;
      end
    end else if (reg_wr && reg_addr == REG_LENGTH) begin
      length_q <= LW'(clamp(reg_wdata, 32'(LEN_RESET), 32'(LEN_MAX)));
    end else if (reg_wr && reg_addr == REG_INDEX) begin
      index_q <= AW'(clamp(reg_wdata, 32'h0000_0000, 32'(DEPTH - 1)));
    end
  end

  // Software trigger pulse and external edge memory
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trig_cmd_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      trig_cmd_q <= reg_wr && (reg_addr == REG_TRIGGER);
      ext_prev_q <= ext_trig;
    end
  end

  // Edge selection of the external trigger
  always_comb begin
    case (ctrl_q.slope)
      SLOPE_FALL: ext_edge = ext_prev_q && !ext_trig;
      SLOPE_BOTH: ext_edge = ext_prev_q != ext_trig;
      default: ext_edge = !ext_prev_q && ext_trig;
    endcase
  end

  assign start = ctrl_q.one_shot_trigger ? (trig_cmd_q || ext_edge) : 1'b1;
  assign sample_done = (timer_q == '0);
  assign last_sample = (LW'(addr_q) + 12'h001 >= length_q);

  // Sequencer: idle, playing, gap between bursts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= SEQ_IDLE;
      addr_q <= '0;
      timer_q <= '0;
      passes_q <= BURST_RESET;
    end else if (!ctrl_q.run || ctrl_q.mode != MODE_PATTERN) begin
      state_q <= SEQ_IDLE;
      addr_q <= '0;
    end else begin
      case (state_q)
        SEQ_IDLE: begin
          if (start) begin
            state_q <= SEQ_PLAY;
            addr_q <= '0;
            timer_q <= sample_period_q - 32'h0000_0001;
            passes_q <= ctrl_q.burst_enable ? burst_repeat_count_q : BURST_RESET;
          end
        end
        SEQ_PLAY: begin
          if (!sample_done) begin
            timer_q <= timer_q - 32'h0000_0001;
          end else if (!last_sample) begin
            addr_q <= addr_q + 11'h001;
            timer_q <= sample_period_q - 32'h0000_0001;
          end else begin
            addr_q <= '0;
            timer_q <= sample_period_q - 32'h0000_0001;
            if (ctrl_q.burst_enable || ctrl_q.one_shot_trigger) begin
              if (passes_q > BURST_RESET) begin
                passes_q <= passes_q - 13'h0001;
              end else if (ctrl_q.burst_enable) begin
                state_q <= SEQ_GAP;
                timer_q <= gap_duration_q - 32'h0000_0001;
              end else begin
                state_q <= SEQ_IDLE;
              end
            end
          end
        end
        SEQ_GAP: begin
          if (!sample_done) begin
            timer_q <= timer_q - 32'h0000_0001;
          end else if (ctrl_q.one_shot_trigger) begin
            state_q <= SEQ_IDLE;
          end else begin
            state_q <= SEQ_PLAY;
            timer_q <= sample_period_q - 32'h0000_0001;
            passes_q <= burst_repeat_count_q;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // PWM step divider
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (tick_cnt_q == 4'(PWM_TICK_CYC - 1));
      tick_cnt_q <= (tick_cnt_q == 4'(PWM_TICK_CYC - 1)) ? '0 : tick_cnt_q + 4'h1;
    end
  end

  // PWM channels: motor speed or red, green, blue; and brightness
  pwm_channel u_pwm0 (
    .clk(clk), .arst_n(arst_n), .step(tick_q),
    .duty((ctrl_q.mode == MODE_MOTOR) ? motor_duty_q : duty_setting_q[0]), .pwm_q(pwm_w[0])
  );
  pwm_channel u_pwm1 (.clk(clk), .arst_n(arst_n), .step(tick_q), .duty(duty_setting_q[1]), .pwm_q(pwm_w[1]));
  pwm_channel u_pwm2 (.clk(clk), .arst_n(arst_n), .step(tick_q), .duty(duty_setting_q[2]), .pwm_q(pwm_w[2]));
  pwm_channel u_pwm3 (.clk(clk), .arst_n(arst_n), .step(tick_q), .duty(brightness_duty_q), .pwm_q(pwm_w[3]));

  // Output pins per mode; in pattern mode low while idle or in a gap
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pattern_out_q <= '0;
    end else begin
      case (ctrl_q.mode)
        MODE_MANUAL: pattern_out_q <= manual_q;
        MODE_MOTOR: pattern_out_q <= {1'b0, ctrl_q.motor_enable, ctrl_q.motor_dir, pwm_w[0]};
        MODE_LED: pattern_out_q <= pwm_w;
        default: pattern_out_q <= (state_q == SEQ_PLAY) ? mem_q[addr_q] : '0;
      endcase
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CTRL: reg_rdata_q <= 32'(ctrl_q);
        REG_LENGTH: reg_rdata_q <= 32'(length_q);
        REG_INDEX: reg_rdata_q <= 32'(index_q);
        REG_APPEND: reg_rdata_q <= 32'(stored);
        REG_SAMPLE: reg_rdata_q <= sample_period_q;
        REG_GAP: reg_rdata_q <= gap_duration_q;
        REG_COUNT: reg_rdata_q <= 32'(burst_repeat_count_q);
        REG_MANUAL: reg_rdata_q <= 32'(manual_q);
        REG_MOTOR: reg_rdata_q <= 32'(motor_duty_q);
        REG_RED: reg_rdata_q <= 32'(duty_setting_q[0]);
        REG_GREEN: reg_rdata_q <= 32'(duty_setting_q[1]);
        REG_BLUE: reg_rdata_q <= 32'(duty_setting_q[2]);
        REG_BRIGHT: reg_rdata_q <= 32'(brightness_duty_q);
        REG_STATUS: reg_rdata_q <= {16'(passes_q), 2'b00, 11'(addr_q), 3'(state_q)};
        default: reg_rdata_q <= '0;
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence append_op_s(append_op_t op);
    wr_append && append_op == op;
  endsequence

  len_range_a: assert property (length_q >= LEN_RESET && length_q <= LEN_MAX)
    else $error("pattern length out of range");
  append_write_a: assert property (append_op_s(APPEND_OVERWRITE) |=> mem_q[$past(index_q)] == $past(append_val))
    else $error("plain append did not store value");
  append_or_a: assert property (append_op_s(APPEND_OR_MERGE) |=> mem_q[$past(index_q)] == ($past(stored) | $past(append_val)))
    else $error("or merge wrong");
  append_and_a: assert property (append_op_s(APPEND_AND_MERGE) |=> mem_q[$past(index_q)] == ($past(stored) & $past(append_val)))
    else $error("and merge wrong");
  append_len_a: assert property (wr_append |=> length_q == LW'($past(index_q)) + 12'h001)
    else $error("append did not set length");
  single_wait_a: assert property (state_q == SEQ_IDLE && ctrl_q.one_shot_trigger && !trig_cmd_q && !ext_edge
    |=> state_q == SEQ_IDLE)
    else $error("one shot started without trigger");
  sample_hold_a: assert property (state_q == SEQ_PLAY && !sample_done && ctrl_q.run && ctrl_q.mode == MODE_PATTERN
    |=> $stable(addr_q))
    else $error("address moved before sample time");
  gap_locked_a: assert property (reg_wr && reg_addr == REG_GAP && !ctrl_q.burst_enable |=> $stable(gap_duration_q))
    else $error("gap written with burst off");
  count_locked_a: assert property (reg_wr && reg_addr == REG_COUNT && !ctrl_q.burst_enable
    |=> $stable(burst_repeat_count_q))
    else $error("burst count written with burst off");
  manual_level_a: assert property (ctrl_q.mode == MODE_MANUAL ##1 ctrl_q.mode == MODE_MANUAL
    |-> pattern_out_q == $past(manual_q))
    else $error("manual level wrong");
  duty_range_a: assert property (motor_duty_q >= DUTY_MIN && motor_duty_q <= DUTY_MAX)
    else $error("motor duty out of range");
  wrap_zero_a: assert property (state_q == SEQ_PLAY && sample_done && last_sample && ctrl_q.run
    && ctrl_q.mode == MODE_PATTERN |=> addr_q == '0)
    else $error("address did not wrap");
endmodule
`default_nettype wire

// ---- verification/target_model.sv ----
// Target model: watches the four pattern pins and drives the external trigger
`timescale 1ns/10ps
`default_nettype none
module target_model
  import pattern_gen_pkg::*;
#(
  parameter int TRIG_HOLD = 30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Trigger request and trigger line
  input wire logic trig_go,
  output logic ext_trig,
  // Pins from the generator
  input wire logic [SW-1:0] pattern_out_q,
  // Activity since the last request
  output int act_cnt,
  output int first_act
);
  int age;

  // Trigger pulse: high for TRIG_HOLD cycles, then low, so both edges appear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_trig <= 1'b0;
      age <= 0;
    end else if (trig_go) begin
      ext_trig <= 1'b1;
      age <= 0;
    end else begin
      age <= age + 1;
      if (age == TRIG_HOLD - 1) begin
        ext_trig <= 1'b0;
      end
    end
  end

  // Cycles with any pin high, and the age of the first one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      act_cnt <= 0;
      first_act <= -1;
    end else if (trig_go) begin
      act_cnt <= 0;
      first_act <= -1;
    end else if (pattern_out_q != '0) begin
      act_cnt <= act_cnt + 1;
      if (first_act < 0) begin
        first_act <= age;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/pattern_generator_tb_top.sv ----
// Self-checking bench for the four-output pattern generator
`timescale 1ns/10ps
`default_nettype none
module pattern_generator_tb_top
  import pattern_gen_pkg::*;
;
  logic clk;
  logic arst_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata_q;
  logic ext_trig;
  logic trig_go;
  logic [SW-1:0] pattern_out_q;
  int act_cnt;
  int first_act;
  int error_cnt;
  int checked;
  int n;
  int hi [4];
  logic [3:0] pat [3] = '{4'h1, 4'h2, 4'h4};
  logic [31:0] app_op [4] = '{32'h0000_0004, 32'h0000_0013, 32'h0000_002d, 32'h0000_0002};
  logic [31:0] app_exp [4] = '{32'h0000_0004, 32'h0000_0007, 32'h0000_0005, 32'h0000_0002};

  pattern_generator #(
    .SAMPLE_MAX_CYC(32'h0000_03e8),
    .GAP_MAX_CYC(32'h0000_03e8),
    .GAP_DEFAULT_CYC(32'h0000_0014)
  ) pattern_generator_i (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .ext_trig(ext_trig), .pattern_out_q(pattern_out_q)
  );

  target_model target_model_i (
    .clk(clk), .arst_n(arst_n), .trig_go(trig_go), .ext_trig(ext_trig),
    .pattern_out_q(pattern_out_q), .act_cnt(act_cnt), .first_act(first_act)
  );

  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Read strobe for one cycle, data taken in the following cycle
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q, exp, what);
  endtask

  task automatic wait_pins(input logic [3:0] v);
    n = 0;
    while (pattern_out_q !== v && n < 50) begin
      tick();
      n++;
    end
    chk(32'(pattern_out_q), 32'(v), "wait pins");
  endtask

  // High cycles of each pin over one full PWM period after settling
  task automatic pwm_meas();
    hi = '{0, 0, 0, 0};
    repeat (1100) tick();
    repeat (1000) begin
      tick();
      for (int b = 0; b < 4; b++) begin
        hi[b] += int'(pattern_out_q[b]);
      end
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish();
  end

  initial begin
    arst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trig_go = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    tick();
    chk(32'(pattern_out_q), 32'h0000_0000, "pins");
    rchk(REG_LENGTH, 32'h0000_0001, "length");
    rchk(REG_SAMPLE, 32'h0000_0002, "sample");
    rchk(REG_COUNT, 32'h0000_0001, "count");
    rchk(REG_CTRL, 32'h0000_0000, "ctrl");
    rchk(REG_GAP, 32'h0000_0014, "gap");
    rchk(REG_MANUAL, 32'h0000_0000, "manual");
    rchk(REG_STATUS, 32'h0001_0001, "status");
    for (int r = 0; r < 5; r++) begin
      rchk(REG_MOTOR + 8'(4 * r), 32'(DUTY_RESET), "duty");
    end
    rchk(8'h3c, 32'h0000_0000, "unmapped");
    $display("test reset done");
    // Length limits, append operations, top of memory
    wr(REG_LENGTH, 32'h0000_0000);
    rchk(REG_LENGTH, 32'h0000_0001, "len lo");
    wr(REG_LENGTH, 32'h0000_1388);
    rchk(REG_LENGTH, 32'(LEN_MAX), "len hi");
    for (int k = 0; k < 4; k++) begin
      wr(REG_INDEX, 32'h0000_0005);
      wr(REG_APPEND, app_op[k]);
      rchk(REG_LENGTH, 32'h0000_0006, "len app");
      wr(REG_INDEX, 32'h0000_0005);
      rchk(REG_APPEND, app_exp[k], "append");
    end
    wr(REG_INDEX, 32'h0000_07ff);
    wr(REG_APPEND, 32'h0000_000a);
    rchk(REG_LENGTH, 32'h0000_0800, "len top");
    wr(REG_INDEX, 32'h0000_07ff);
    rchk(REG_APPEND, 32'h0000_000a, "mem top");
    wr(REG_INDEX, 32'h0000_0000);
    for (int k = 0; k < 3; k++) begin
      wr(REG_APPEND, 32'(pat[k]));
    end
    rchk(REG_LENGTH, 32'h0000_0003, "len 3");
    wr(REG_SAMPLE, 32'h0000_0001);
    rchk(REG_SAMPLE, 32'h0000_0002, "sample lo");
    wr(REG_SAMPLE, 32'h0000_0003);
    $display("test append done");
    // Free-running replay, three cycles per sample, wrap after the third
    wr(REG_CTRL, 32'h0000_0004);
    wait_pins(4'h1);
    for (int i = 0; i < 12; i++) begin
      chk(32'(pattern_out_q), 32'(pat[(i / 3) % 3]), "replay");
      tick();
    end
    $display("test replay done");
    // One shot by software trigger: nothing before it, one pass after it
    wr(REG_CTRL, 32'h0000_0014);
    repeat (10) tick();
    chk(32'(pattern_out_q), 32'h0000_0000, "no start");
    wr(REG_TRIGGER, 32'h0000_0000);
    wait_pins(4'h1);
    for (int i = 0; i < 9; i++) begin
      chk(32'(pattern_out_q), 32'(pat[i / 3]), "one pass");
      tick();
    end
    n = 0;
    repeat (30) begin
      tick();
      n += int'(pattern_out_q != 4'h0);
    end
    chk(32'(n), 32'h0000_0000, "stays idle");
    // External trigger on rise, fall and both edges
    for (int s = 0; s < 3; s++) begin
      wr(REG_CTRL, 32'h0000_0014 | 32'(s << 5));
      @(posedge clk);
      trig_go <= 1'b1;
      @(posedge clk);
      trig_go <= 1'b0;
      repeat (80) tick();
      chk(32'(act_cnt), (s == 2) ? 32'h0000_0012 : 32'h0000_0009, "trig passes");
      chk(32'(first_act < 30), 32'(s != 1), "trig edge");
    end
    $display("test trigger done");
    // Burst: count and gap dropped while off, two passes then a gap
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_COUNT, 32'h0000_0007);
    rchk(REG_COUNT, 32'h0000_0001, "count off");
    wr(REG_GAP, 32'h0000_0005);
    rchk(REG_GAP, 32'h0000_0014, "gap off");
    wr(REG_CTRL, 32'h0000_0008);
    wr(REG_COUNT, 32'h0000_1388);
    rchk(REG_COUNT, 32'(BURST_MAX), "count hi");
    wr(REG_GAP, 32'h0000_0001);
    rchk(REG_GAP, 32'h0000_0002, "gap lo");
    wr(REG_GAP, 32'h0000_001e);
    wr(REG_COUNT, 32'h0000_0002);
    rchk(REG_COUNT, 32'h0000_0002, "count");
    wr(REG_CTRL, 32'h0000_000c);
    wait_pins(4'h1);
    repeat (2) begin
      n = 0;
      while (pattern_out_q != 4'h0 && n < 100) begin
        tick();
        n++;
      end
      chk(32'(n), 32'h0000_0012, "burst run");
      n = 0;
      while (pattern_out_q === 4'h0 && n < 100) begin
        tick();
        n++;
      end
      chk(32'(n >= 30 && n <= 33), 32'h0000_0001, "gap run");
    end
    $display("test burst done");
    // Manual levels
    wr(REG_CTRL, 32'h0000_0001);
    for (int k = 0; k < 6; k++) begin
      wr(REG_MANUAL, (k < 4) ? 32'(1 << k) : ((k == 4) ? 32'h0000_000f : 32'h0000_0000));
      tick();
      tick();
      chk(32'(pattern_out_q), (k < 4) ? 32'(1 << k) : ((k == 4) ? 32'h0000_000f : 32'h0000_0000), "manual");
    end
    $display("test manual done");
    // Motor speed, direction and enable
    wr(REG_MOTOR, 32'h0000_0000);
    rchk(REG_MOTOR, 32'(DUTY_MIN), "duty lo");
    wr(REG_CTRL, 32'h0000_0102);
    pwm_meas();
    chk(32'(hi[0]), 32'h0000_000a, "speed 1");
    chk(32'(hi[1] + 2 * hi[2] + 4 * hi[3]), 32'h0000_07d0, "dir0 en1");
    wr(REG_MOTOR, 32'h0000_0063);
    wr(REG_CTRL, 32'h0000_0082);
    pwm_meas();
    chk(32'(hi[0]), 32'h0000_03de, "speed 99");
    chk(32'(hi[1] + 2 * hi[2] + 4 * hi[3]), 32'h0000_03e8, "dir1 en0");
    $display("test motor done");
    // Light colour and brightness
    for (int k = 0; k < 4; k++) begin
      wr(REG_RED + 8'(4 * k), 32'(10 * (k + 1)));
    end
    wr(REG_CTRL, 32'h0000_0003);
    pwm_meas();
    for (int k = 0; k < 4; k++) begin
      chk(32'(hi[k]), 32'(100 * (k + 1)), "led duty");
    end
    $display("test led done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
